// ---- design/gpio_pkg.sv ----
package gpio_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] port_a_data_addr = 9'h005;
  localparam logic [8:0] port_b_data_addr = 9'h006;
  localparam logic [8:0] port_c_data_addr = 9'h007;
  localparam logic [8:0] interrupt_control_addr = 9'h00b;
  localparam logic [8:0] timer_pullup_config_addr = 9'h081;
  localparam logic [8:0] port_a_direction_addr = 9'h085;
  localparam logic [8:0] port_b_direction_addr = 9'h086;
  localparam logic [8:0] port_c_direction_addr = 9'h087;
  localparam logic [8:0] analog_pin_config_addr = 9'h09f;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int pullup_disable_bit = 7;
  localparam int change_flag_bit = 0;
  localparam int timer_clock_bit = 4;
  localparam int slave_select_bit = 5;
  localparam logic [7:0] option_reset = 8'hff;
  localparam logic [5:0] port_a_dir_reset = 6'h3f;
  localparam logic [7:0] port_b_dir_reset = 8'hff;
  localparam logic [5:0] port_c_dir_reset = 6'h3f;
  localparam logic [2:0] analog_field_reset = 3'h0;
  localparam logic [5:0] port_a_data_reset = 6'h00;
  // analog select code that makes every port a pin digital
  localparam logic [2:0] analog_all_digital = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] a_out;
    logic [5:0] a_oe;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [7:0] b_pullup;
    logic [5:0] c_out;
    logic [5:0] c_oe;
  } pin_drive_t;

  typedef struct packed {
    logic [5:0] a_lat;
    logic [5:0] a_dir;
    logic [7:0] b_lat;
    logic [7:0] b_dir;
    logic [5:0] c_lat;
    logic [5:0] c_dir;
    logic [7:0] option;
    logic [2:0] analog_sel;
    logic [3:0] b_snap;
    logic change_flag;
    logic [7:0] rdata;
    pin_drive_t drive;
    logic timer_ext_clock;
    logic ext_interrupt;
    logic slave_select;
    logic wake;
  } gpio_state_t;

endpackage

// ---- design/gpio_ports.sv ----
// Functional notes
// R1: direction one tri-states the pin; zero drives it from the output latch
// R2: data register reads return pin levels; writes update only the latch
// R3: port writes are read-modify-write using sampled pin levels
// R4: port A bit 4 is open-drain, Schmitt input, feeds timer external clock
// R5: three-bit analog field selects analog pins; analog pins read zero
// R6: port A direction still controls drivers in analog mode
// R7: port A and its direction keep bits 5..0; bits 7..6 read zero
// R8: port A data resets to zeros except bit 4 on the analog variant
// R9: port B is eight bits with the same direction convention
// R10: clearing pull-up disable bit 7 turns on all port B pull-ups
// R11: a port B pin set as output has its pull-up off
// R12: pull-ups are off after reset since the option register resets to ones
// R13: change detect covers port B bits 7..4 configured as inputs only
// R14: inputs compare to copy latched on last port B read; mismatch sets flag (code also reloads the copy on port B writes)
// R15: flag keeps being set while a mismatch persists
// R16: a pending port change flag raises the wake request
// R17: software should not poll port B while using change detection
// R18: port B bit 0 also drives the external interrupt input
// R19: port B bits 7 and 6 are serial programming clock and data
// R20: port A bit 5 also gives the serial port slave-select input
// R21: port C is six bits; enabled peripherals force direction while enabled
// R22: software should avoid bit-modify writes to port C direction under override
// R23: flag stays until written zero; a same-cycle mismatch wins the clear
module gpio_ports
  import gpio_pkg::*;
#(
  parameter bit has_analog = 1'b1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // pins
  input wire logic [5:0] a_pin_in,
  input wire logic [7:0] b_pin_in,
  input wire logic [5:0] c_pin_in,
  output pin_drive_t drive,
  // peripheral direction override for port c
  input wire logic [5:0] c_ovr_en,
  input wire logic [5:0] c_ovr_dir,
  input wire logic [5:0] c_ovr_out,
  // peripheral side signals
  input wire logic serial_prog_mode,
  output logic timer_ext_clock,
  output logic ext_interrupt,
  output logic slave_select,
  output logic port_change_flag,
  output logic wake
);

  gpio_state_t st_r;
  gpio_state_t st_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // mask of port a pins in analog mode; per-code table decode of the field, all zero without has_analog
  function automatic logic [5:0] analog_mask(input logic [2:0] sel);
    logic [5:0] m;
    m = 6'h00;
    if (has_analog)
    begin
      case (sel)
        3'h0: m = 6'h2f;
        3'h1: m = 6'h2f;
        3'h2: m = 6'h2f;
        3'h3: m = 6'h0f;
        3'h4: m = 6'h0b;
        3'h5: m = 6'h03;
        3'h6: m = 6'h01;
        default: m = 6'h00;
      endcase
    end
    return m;
  endfunction

  logic [5:0] a_read;
  logic [5:0] c_dir_eff;
  logic [3:0] mismatch;

  // pin value seen by a read; analog pins read zero
  assign a_read = a_pin_in & ~analog_mask(st_r.analog_sel); // [R2] [R5]
  // peripheral override holds direction only while it stays enabled
  assign c_dir_eff = (st_r.c_dir & ~c_ovr_en) | (c_ovr_dir & c_ovr_en); // [R21]
  // only input pins of the upper nibble take part in the comparison
  assign mismatch = (b_pin_in[7:4] ^ st_r.b_snap) & st_r.b_dir[7:4]; // [R13] [R14]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // flag set by any mismatch, every cycle it persists
    if (|mismatch)
    begin
      st_nxt.change_flag = 1'b1; // [R15]
    end
    if (req.wr)
    begin
      case (req.addr)
        // writes go to the latch only; pins untouched until driven [R3]
        port_a_data_addr: st_nxt.a_lat = req.wdata[5:0]; // [R2] [R7]
        port_b_data_addr:
        begin
          st_nxt.b_lat = req.wdata;
          st_nxt.b_snap = b_pin_in[7:4]; // write ends the mismatch too
        end
        port_c_data_addr: st_nxt.c_lat = req.wdata[5:0];
        interrupt_control_addr:
        begin
          // set beats clear when a mismatch shows in the same cycle
          st_nxt.change_flag = req.wdata[change_flag_bit] | (|mismatch); // [R23]
        end
        timer_pullup_config_addr: st_nxt.option = req.wdata;
        port_a_direction_addr: st_nxt.a_dir = req.wdata[5:0]; // [R7]
        port_b_direction_addr: st_nxt.b_dir = req.wdata; // [R9]
        port_c_direction_addr: st_nxt.c_dir = req.wdata[5:0];
        analog_pin_config_addr:
        begin
          if (has_analog)
          begin
            st_nxt.analog_sel = req.wdata[2:0]; // [R5]
          end
        end
        default: st_nxt.option = st_r.option;
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        port_a_data_addr: st_nxt.rdata = {2'b00, a_read}; // [R7]
        port_b_data_addr:
        begin
          st_nxt.rdata = b_pin_in; // [R2]
          st_nxt.b_snap = b_pin_in[7:4]; // reload comparison copy [R14]
        end
        port_c_data_addr: st_nxt.rdata = {2'b00, c_pin_in};
        interrupt_control_addr: st_nxt.rdata = {7'h00, st_r.change_flag};
        timer_pullup_config_addr: st_nxt.rdata = st_r.option;
        port_a_direction_addr: st_nxt.rdata = {2'b00, st_r.a_dir};
        port_b_direction_addr: st_nxt.rdata = st_r.b_dir;
        port_c_direction_addr: st_nxt.rdata = {2'b00, st_r.c_dir};
        analog_pin_config_addr: st_nxt.rdata = {5'h00, st_r.analog_sel};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // pin drivers: direction one means high impedance [R1]
    st_nxt.drive.a_out = st_r.a_lat;
    st_nxt.drive.a_oe = ~st_r.a_dir; // [R6]
    // open drain: only ever pulls low [R4]
    st_nxt.drive.a_out[timer_clock_bit] = 1'b0;
    st_nxt.drive.a_oe[timer_clock_bit] = ~st_r.a_dir[timer_clock_bit] &
                                         ~st_r.a_lat[timer_clock_bit];
    st_nxt.drive.b_out = st_r.b_lat;
    st_nxt.drive.b_oe = ~st_r.b_dir; // [R9]
    // pull-ups on only for inputs with global enable low
    st_nxt.drive.b_pullup = {8{~st_r.option[pullup_disable_bit]}} & st_r.b_dir; // [R10] [R11]
    st_nxt.drive.c_out = (st_r.c_lat & ~c_ovr_en) | (c_ovr_out & c_ovr_en);
    st_nxt.drive.c_oe = ~c_dir_eff; // [R21]
    // alternate input functions
    st_nxt.timer_ext_clock = a_pin_in[timer_clock_bit]; // [R4]
    st_nxt.slave_select = a_pin_in[slave_select_bit]; // [R20]
    st_nxt.ext_interrupt = b_pin_in[0]; // [R18]
    st_nxt.wake = st_nxt.change_flag; // [R16]
    // serial programming mode releases bits 7..6 so the programmer owns them
    if (serial_prog_mode)
    begin
      st_nxt.drive.b_oe[7:6] = 2'b00; // [R19]
      st_nxt.drive.b_pullup[7:6] = 2'b00;
    end
    if (sys_rst)
    begin
      st_nxt = '0;
      st_nxt.a_dir = port_a_dir_reset;
      st_nxt.b_dir = port_b_dir_reset;
      st_nxt.c_dir = port_c_dir_reset;
      st_nxt.option = option_reset; // [R12]
      st_nxt.analog_sel = analog_field_reset;
      st_nxt.a_lat = port_a_data_reset; // [R8]
      st_nxt.drive.a_oe = 6'h00;
      st_nxt.drive.b_oe = 8'h00;
      st_nxt.drive.c_oe = 6'h00;
    end
  end

  // single state register; sync reset handled in the comb path
  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = st_r.rdata;
  assign drive = st_r.drive;
  assign timer_ext_clock = st_r.timer_ext_clock;
  assign ext_interrupt = st_r.ext_interrupt;
  assign slave_select = st_r.slave_select;
  assign port_change_flag = st_r.change_flag;
  assign wake = st_r.wake;

endmodule

// ---- test/gpio_ports_chk.sv ----
module gpio_ports_chk
  import gpio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port and pins
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic [5:0] a_pin_in,
  input wire logic [7:0] b_pin_in,
  input wire pin_drive_t drive,
  // side signals
  input wire logic timer_ext_clock,
  input wire logic ext_interrupt,
  input wire logic port_change_flag,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // read data only in the cycle after a read
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  port_b_read_a: assert property (req.rd && req.addr == port_b_data_addr
    |=> rdata == $past(b_pin_in))
    else $error("port b read is not the pin level");
  dir_upper_a: assert property (req.rd && req.addr == port_a_direction_addr
    |=> rdata[7:6] == 2'b00)
    else $error("port a direction upper bits set");
  // copies lag the pins by one edge; skip the edge leaving reset
  timer_copy_a: assert property (!$past(sys_rst)
    |-> timer_ext_clock == $past(a_pin_in[4]))
    else $error("timer clock does not follow pin");
  ext_int_a: assert property (!$past(sys_rst)
    |-> ext_interrupt == $past(b_pin_in[0]))
    else $error("external interrupt does not follow pin");
  // wake is registered from the same next value as the flag, so both move together
  wake_a: assert property (wake == port_change_flag)
    else $error("wake does not follow flag");
  open_drain_a: assert property (drive.a_oe[4] |-> drive.a_out[4] == 1'b0)
    else $error("open drain pin driven high");
  pullup_out_a: assert property ((drive.b_pullup & drive.b_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  b_dir_drive_a: assert property (req.wr && req.addr == port_b_direction_addr
    |-> ##2 drive.b_oe == ~$past(req.wdata, 2))
    else $error("port b enables do not follow direction");
  flag_clear_a: assert property ($fell(port_change_flag)
    |-> $past(req.wr) || $past(req.wr, 2))
    else $error("flag dropped without a write");
endmodule

// ---- test/gpio_pins.sv ----
module gpio_pins
  import gpio_pkg::*;
(
  // design drive and board levels
  input wire pin_drive_t drive,
  input wire logic [5:0] a_ext,
  input wire logic [7:0] b_ext,
  input wire logic [5:0] c_ext,
  // resolved levels
  output logic [5:0] a_pin_in,
  output logic [7:0] b_pin_in,
  output logic [5:0] c_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin shows the design's output value, a released one the board
  assign a_pin_in = (drive.a_oe & drive.a_out) | (~drive.a_oe & a_ext);
  assign b_pin_in = (drive.b_oe & drive.b_out) | (~drive.b_oe & b_ext);
  assign c_pin_in = (drive.c_oe & drive.c_out) | (~drive.c_oe & c_ext);
endmodule

// ---- test/gpio_ports_test.sv ----
`define chk(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
  end
module gpio_ports_test
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata, d, b_pin_in;
  logic [7:0] b_ext = 8'h3c;
  logic [5:0] a_pin_in, c_pin_in;
  logic [5:0] a_ext = 6'h3f;
  logic [5:0] c_ext = 6'h2a;
  logic [5:0] c_ovr_en = 6'h00;
  logic [5:0] c_ovr_dir = 6'h00;
  logic [5:0] c_ovr_out = 6'h00;
  logic serial_prog_mode = 1'b0;
  pin_drive_t drive;
  logic timer_ext_clock, ext_interrupt, slave_select, port_change_flag, wake;
  int bad_count = 0;
  int cmp_count = 0;

  // clock, 100 ns period
  initial
  begin
    forever #50 clk = ~clk;
  end

  gpio_ports i_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .a_pin_in(a_pin_in), .b_pin_in(b_pin_in), .c_pin_in(c_pin_in), .drive(drive),
    .c_ovr_en(c_ovr_en), .c_ovr_dir(c_ovr_dir), .c_ovr_out(c_ovr_out),
    .serial_prog_mode(serial_prog_mode),
    .timer_ext_clock(timer_ext_clock), .ext_interrupt(ext_interrupt),
    .slave_select(slave_select), .port_change_flag(port_change_flag), .wake(wake));
  gpio_pins i_pins (.drive(drive), .a_ext(a_ext), .b_ext(b_ext), .c_ext(c_ext),
    .a_pin_in(a_pin_in), .b_pin_in(b_pin_in), .c_pin_in(c_pin_in));

  // one-cycle bus strobes; each task waits for a clock edge before it sets req
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  // drive outputs land one edge after the register does
  task automatic lag(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rd(port_a_direction_addr);
    `chk(d, 8'h3f)
    rd(port_b_direction_addr);
    `chk(d, 8'hff)
    rd(timer_pullup_config_addr);
    `chk(d, 8'hff)
    rd(port_a_data_addr);
    `chk(d, 8'h10)
    `chk(slave_select, 1'b1)
    rd(9'h0ff);
    `chk(d, 8'h00)
    `chk(drive.b_pullup, 8'h00)
  endtask

  task automatic t_drive;
    wr(port_b_direction_addr, 8'h00);
    wr(port_b_data_addr, 8'ha5);
    lag(1);
    `chk(drive.b_oe, 8'hff)
    `chk(drive.b_out, 8'ha5)
    rd(port_b_data_addr);
    `chk(d, 8'ha5)
    // programming mode hands bits 7..6 to the programmer
    @(posedge clk);
    serial_prog_mode <= 1'b1;
    lag(1);
    `chk(drive.b_oe, 8'h3f)
    @(posedge clk);
    serial_prog_mode <= 1'b0;
    wr(port_b_direction_addr, 8'h0f);
    wr(timer_pullup_config_addr, 8'h7f);
    lag(1);
    `chk(drive.b_pullup, 8'h0f)
    wr(port_b_direction_addr, 8'hff);
    wr(timer_pullup_config_addr, 8'hff);
    lag(1);
    `chk(drive.b_pullup, 8'h00)
  endtask

  task automatic t_change;
    rd(port_b_data_addr); // one read only, no polling
    // clear what the pins showed since reset, now the copy matches
    wr(interrupt_control_addr, 8'h00);
    @(posedge clk);
    b_ext <= 8'h38;
    lag(3);
    `chk(port_change_flag, 1'b0)
    @(posedge clk);
    b_ext <= 8'h78;
    lag(3);
    `chk(port_change_flag, 1'b1)
    lag(1);
    `chk(wake, 1'b1)
    wr(interrupt_control_addr, 8'h00);
    lag(1);
    `chk(port_change_flag, 1'b1)
    rd(port_b_data_addr);
    wr(interrupt_control_addr, 8'h00);
    lag(1);
    `chk(port_change_flag, 1'b0)
  endtask

  task automatic t_port_a;
    wr(analog_pin_config_addr, 8'h07);
    @(posedge clk);
    a_ext <= 6'h1a;
    rd(port_a_data_addr);
    `chk(d, 8'h1a)
    `chk(timer_ext_clock, 1'b1)
    `chk(slave_select, 1'b0)
    wr(port_a_direction_addr, 8'h00);
    wr(port_a_data_addr, 8'h3f);
    lag(1);
    `chk(drive.a_oe, 6'h2f)
    `chk(drive.a_out, 6'h2f)
    // back to analog: direction still rules the drivers
    wr(analog_pin_config_addr, 8'h00);
    lag(1);
    `chk(drive.a_oe, 6'h2f)
    rd(port_a_data_addr);
    `chk(d, 8'h10)
    wr(port_a_direction_addr, 8'h3f);
    lag(1);
    `chk(drive.a_oe, 6'h00)
  endtask

  task automatic t_port_c;
    wr(port_c_direction_addr, 8'h30); // whole byte, no bit-modify under override
    wr(port_c_data_addr, 8'h15);
    lag(1);
    `chk(drive.c_oe, 6'h0f)
    rd(port_c_data_addr);
    `chk(d, 8'h25)
    // a peripheral takes bits 1..0: bit 0 input, bit 1 driven high
    @(posedge clk);
    c_ovr_en <= 6'h03;
    c_ovr_dir <= 6'h01;
    c_ovr_out <= 6'h02;
    lag(1);
    `chk(drive.c_oe, 6'h0e)
    `chk(drive.c_out, 6'h16)
    rd(port_c_direction_addr);
    `chk(d, 8'h30)
    @(posedge clk);
    c_ovr_en <= 6'h00;
    lag(1);
    `chk(drive.c_oe, 6'h0f)
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_drive();
    t_change();
    t_port_a();
    t_port_c();
    give_verdict();
  end

  // the run needs about 90 cycles
  initial
  begin
    #200us;
    bad_count++;
    give_verdict();
  end
endmodule

bind gpio_ports gpio_ports_chk i_chk (.clk(clk), .sys_rst(sys_rst), .req(req),
  .rdata(rdata), .a_pin_in(a_pin_in), .b_pin_in(b_pin_in), .drive(drive),
  .timer_ext_clock(timer_ext_clock), .ext_interrupt(ext_interrupt),
  .port_change_flag(port_change_flag), .wake(wake));
